// file: hdl/ecc_pkg.sv
// ---------------------------------------------------------------------------
// ecc_pkg: register map, field positions and mode codes of the capture unit
// ---------------------------------------------------------------------------
// assumes a 32-bit classic wishbone slave with one register per aligned word
package ecc_pkg;

    // word-aligned byte offsets
    localparam logic [7:0] ECC_OFS_MODE    = 8'h00; // unit mode control
    localparam logic [7:0] ECC_OFS_VAL_LO  = 8'h04; // compare value low byte
    localparam logic [7:0] ECC_OFS_VAL_HI  = 8'h08; // compare value high byte
    localparam logic [7:0] ECC_OFS_T3CTL   = 8'h0C; // timer three control
    localparam logic [7:0] ECC_OFS_FLAG    = 8'h10; // irq flag, write 1 to clear

    // mode control fields
    localparam int ECC_STEER_HI   = 7;
    localparam int ECC_STEER_LO   = 6;
    localparam int ECC_DUTY_HI    = 5;
    localparam int ECC_DUTY_LO    = 4;
    localparam int ECC_POL_AC_BIT = 1;
    localparam int ECC_POL_BD_BIT = 0;
    localparam int ECC_TSEL_BIT   = 3;  // time base select in timer three control
    localparam int ECC_FLAG_BIT   = 0;

    // reset values
    localparam logic [7:0] ECC_MODE_RST  = 8'h00;
    localparam logic [7:0] ECC_VAL_RST   = 8'h00;
    localparam logic [7:0] ECC_T3CTL_RST = 8'h00;
    localparam logic [3:0] ECC_PRESC_RST = 4'h0;

    // mode field codes
    typedef enum logic [3:0] {
        ECC_M_OFF      = 4'b0000,
        ECC_M_RSV1     = 4'b0001,
        ECC_M_CMP_TGL  = 4'b0010,
        ECC_M_RSV3     = 4'b0011,
        ECC_M_CAP_FALL = 4'b0100,
        ECC_M_CAP_RISE = 4'b0101,
        ECC_M_CAP_R4   = 4'b0110,
        ECC_M_CAP_R16  = 4'b0111,
        ECC_M_CMP_SET  = 4'b1000,
        ECC_M_CMP_CLR  = 4'b1001,
        ECC_M_CMP_SW   = 4'b1010,
        ECC_M_CMP_SPEC = 4'b1011
    } ecc_mode_e;

    // output steering in pwm
    localparam logic [1:0] ECC_STEER_SINGLE = 2'b00;
    localparam logic [1:0] ECC_STEER_FWD    = 2'b01;
    localparam logic [1:0] ECC_STEER_HALF   = 2'b10;
    localparam logic [1:0] ECC_STEER_REV    = 2'b11;

    // prescaler terminal counts
    localparam logic [3:0] ECC_PRESC_4  = 4'h3;
    localparam logic [3:0] ECC_PRESC_16 = 4'hF;

endpackage

// file: hdl/ecc_unit.sv
// ---------------------------------------------------------------------------
// ecc_unit: enhanced capture/compare unit with pwm output steering
// ---------------------------------------------------------------------------
// assumes timers one and three count on clk_i; pwm waveform and its dead-band
// complement come from a timer two generator on the same clock.
// Contract
// - mode zero turns unit off, clears compare latch and prescaler
// - mode codes 0001 and 0011 are reserved, unit does nothing
// - capture on falling, rising, every 4th or every 16th rising edge
// - mode 0010 toggles compare output on match and sets flag
// - mode 1000 drives output high, 1001 low on match; both set flag
// - mode 1010 only sets flag; pin goes back to port use
// - mode 1011 sets flag, resets selected timer, starts conversion if enabled
// - pwm modes; bit1 inverts outputs a and c, bit0 inverts b and d
// - outside pwm, steering ignored; a is capture/compare, b to d port pins
// - steering 00: only output a modulated
// - steering 01: d modulated, a active, b and c inactive
// - steering 10: a and b complementary modulated, c and d port pins
// - steering 11: b modulated, c active, a and d inactive
// - duty is low compare byte above the two duty lsb bits
// - qualified capture copies full 16-bit selected timer count
// - every capture sets flag; only software clears it
// - new capture overwrites pair, no overrun indication
// - capture/compare use timer one or three; pwm uses timer two
// - prescaler cleared when off or not in capture
// - changing between prescalers keeps the prescaler count
// - time base select bit 3: one picks timer three, zero timer one
`timescale 1ns/1ns
module ecc_unit
    import ecc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // time bases
    input  wire logic [15:0] timer_one_count_i,
    input  wire logic [15:0] timer_three_count_i,
    output logic             timer_one_reset_o,
    output logic             timer_three_reset_o,
    input  wire logic        adc_enabled_i,
    output logic             adc_start_o,
    // pwm generator on timer two
    input  wire logic        pwm_mod_i,
    input  wire logic        pwm_comp_i,
    output logic      [9:0]  duty_cycle_o,
    // pins
    input  wire logic        capture_pin_i,
    output logic             output_a_o,
    output logic             output_a_oe_o,
    output logic             output_b_o,
    output logic             output_b_oe_o,
    output logic             output_c_o,
    output logic             output_c_oe_o,
    output logic             output_d_o,
    output logic             output_d_oe_o,
    output logic             unit_irq_flag_o
);

    // -----------------------------------------------------------------------
    // state
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  val_lo;
        logic [7:0]  val_hi;
        logic [7:0]  t3ctl;
        logic        flag;
        logic        pin_s1;
        logic        pin_s2;
        logic        pin_prev;
        logic [3:0]  presc;
        logic        cmp_latch;
        logic        match_prev;
        logic        ack;
        logic [31:0] rdata;
        logic        trst1;
        logic        trst3;
        logic        adc_go;
        logic [3:0]  pin_val;
        logic [3:0]  pin_oe;
    } ecc_state_s;

    localparam ecc_state_s ECC_STATE_RST = '{
        mode: ECC_MODE_RST, val_lo: ECC_VAL_RST, val_hi: ECC_VAL_RST,
        t3ctl: ECC_T3CTL_RST, presc: ECC_PRESC_RST, rdata: 32'h0000_0000,
        pin_val: 4'h0, pin_oe: 4'h0, default: 1'b0};

    ecc_state_s q_reg;
    ecc_state_s q_next;

    // address decode, shared by read and write paths
    function automatic logic [2:0] ecc_decode(input logic [7:0] adr);
        case (adr)
            ECC_OFS_MODE:   ecc_decode = 3'h1;
            ECC_OFS_VAL_LO: ecc_decode = 3'h2;
            ECC_OFS_VAL_HI: ecc_decode = 3'h3;
            ECC_OFS_T3CTL:  ecc_decode = 3'h4;
            ECC_OFS_FLAG:   ecc_decode = 3'h5;
            default:        ecc_decode = 3'h0;
        endcase
    endfunction

    // -----------------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------------
    logic [3:0]  mfield;
    logic [1:0]  steer;
    logic [15:0] tbase;
    logic [15:0] cmp_val;
    logic        is_cap;
    logic        is_cmp;
    logic        is_pwm;
    logic        rise;
    logic        fall;
    logic        cap_evt;
    logic        match_evt;
    logic        wr_en;
    logic [2:0]  wsel;
    logic        pol_ac;
    logic        pol_bd;

    always_comb begin
        q_next    = q_reg;
        mfield    = q_reg.mode[3:0];
        steer     = q_reg.mode[ECC_STEER_HI:ECC_STEER_LO];
        pol_ac    = q_reg.mode[ECC_POL_AC_BIT];
        pol_bd    = q_reg.mode[ECC_POL_BD_BIT];
        is_cap    = (mfield[3:2] == 2'b01);
        is_cmp    = (mfield == ECC_M_CMP_TGL) || (mfield[3:2] == 2'b10);
        is_pwm    = (mfield[3:2] == 2'b11);
        tbase     = q_reg.t3ctl[ECC_TSEL_BIT] ? timer_three_count_i
                                              : timer_one_count_i;
        cmp_val   = {q_reg.val_hi, q_reg.val_lo};
        wsel      = ecc_decode(adr_i);
        wr_en     = cyc_i && stb_i && we_i && q_reg.ack && sel_i[0];

        // two-stage sync; only the second stage feeds edge logic
        q_next.pin_s1   = capture_pin_i;
        q_next.pin_s2   = q_reg.pin_s1;
        q_next.pin_prev = q_reg.pin_s2;
        rise = q_reg.pin_s2 && !q_reg.pin_prev;
        fall = !q_reg.pin_s2 && q_reg.pin_prev;

        // capture qualification with prescaler; count kept across prescaler swaps
        cap_evt = 1'b0;
        if (is_cap) begin
            case (mfield)
                ECC_M_CAP_FALL: cap_evt = fall;
                ECC_M_CAP_RISE: cap_evt = rise;
                ECC_M_CAP_R4:   cap_evt = rise && (q_reg.presc[1:0] == ECC_PRESC_4[1:0]);
                ECC_M_CAP_R16:  cap_evt = rise && (q_reg.presc == ECC_PRESC_16);
                default:        cap_evt = 1'b0;
            endcase
            if (rise) begin
                q_next.presc = q_reg.presc + 4'h1;
            end
        end else begin
            q_next.presc = ECC_PRESC_RST;
        end

        // compare match on first cycle of equality, so a stalled timer acts once
        q_next.match_prev = is_cmp && (tbase == cmp_val);
        match_evt = is_cmp && (tbase == cmp_val) && !q_reg.match_prev;

        // one-cycle trigger pulses default low
        q_next.trst1  = 1'b0;
        q_next.trst3  = 1'b0;
        q_next.adc_go = 1'b0;
        if (match_evt) begin
            case (mfield)
                ECC_M_CMP_TGL:  q_next.cmp_latch = !q_reg.cmp_latch;
                ECC_M_CMP_SET:  q_next.cmp_latch = 1'b1;
                ECC_M_CMP_CLR:  q_next.cmp_latch = 1'b0;
                ECC_M_CMP_SPEC: begin
                    q_next.trst1  = !q_reg.t3ctl[ECC_TSEL_BIT];
                    q_next.trst3  = q_reg.t3ctl[ECC_TSEL_BIT];
                    q_next.adc_go = adc_enabled_i;
                end
                default:        q_next.cmp_latch = q_reg.cmp_latch;
            endcase
        end
        if (mfield == ECC_M_OFF) begin
            q_next.cmp_latch = 1'b0;
        end

        // wishbone: ack one cycle after request, drop after one cycle
        q_next.ack = cyc_i && stb_i && !q_reg.ack;
        q_next.rdata = 32'h0000_0000;
        case (wsel)
            3'h1:    q_next.rdata[7:0] = q_reg.mode;
            3'h2:    q_next.rdata[7:0] = q_reg.val_lo;
            3'h3:    q_next.rdata[7:0] = q_reg.val_hi;
            3'h4:    q_next.rdata[7:0] = q_reg.t3ctl;
            3'h5:    q_next.rdata[ECC_FLAG_BIT] = q_reg.flag;
            default: q_next.rdata = 32'h0000_0000;
        endcase

        // software writes take effect on the acknowledged edge
        if (wr_en) begin
            case (wsel)
                3'h1:    q_next.mode   = dat_i[7:0];
                3'h2:    q_next.val_lo = dat_i[7:0];
                3'h3:    q_next.val_hi = dat_i[7:0];
                3'h4:    q_next.t3ctl  = dat_i[7:0];
                3'h5:    q_next.flag   = q_reg.flag && !dat_i[ECC_FLAG_BIT];
                default: q_next.flag   = q_reg.flag;
            endcase
        end

        // hardware events win over software in the same cycle
        if (cap_evt) begin
            q_next.val_lo = tbase[7:0];
            q_next.val_hi = tbase[15:8];
            q_next.flag   = 1'b1;
        end
        if (match_evt) begin
            q_next.flag = 1'b1;
        end

        // pin steering; outside pwm only output a belongs to the unit
        q_next.pin_oe  = 4'h0;
        q_next.pin_val = 4'h0;
        if (is_pwm) begin
            case (steer)
                ECC_STEER_SINGLE: begin
                    q_next.pin_oe  = 4'b0001;
                    q_next.pin_val = {3'b000, pwm_mod_i ^ pol_ac};
                end
                ECC_STEER_FWD: begin
                    q_next.pin_oe  = 4'b1111;
                    q_next.pin_val = {pwm_mod_i ^ pol_bd, pol_ac, pol_bd, !pol_ac};
                end
                ECC_STEER_HALF: begin
                    q_next.pin_oe  = 4'b0011;
                    q_next.pin_val = {2'b00, pwm_comp_i ^ pol_bd, pwm_mod_i ^ pol_ac};
                end
                default: begin
                    q_next.pin_oe  = 4'b1111;
                    q_next.pin_val = {pol_bd, !pol_ac, pwm_mod_i ^ pol_bd, pol_ac};
                end
            endcase
        end else if (is_cmp && mfield != ECC_M_CMP_SW) begin
            q_next.pin_oe  = 4'b0001;
            q_next.pin_val = {3'b000, q_next.cmp_latch};
        end
        // reserved codes and capture leave every pin to the port
    end

    // -----------------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_reg <= ECC_STATE_RST;
        end else begin
            q_reg <= q_next;
        end
    end

    // outputs straight from flops
    assign dat_o               = q_reg.rdata;
    assign ack_o               = q_reg.ack;
    assign timer_one_reset_o   = q_reg.trst1;
    assign timer_three_reset_o = q_reg.trst3;
    assign adc_start_o         = q_reg.adc_go;
    assign duty_cycle_o        = {q_reg.val_lo, q_reg.mode[ECC_DUTY_HI:ECC_DUTY_LO]};
    assign unit_irq_flag_o     = q_reg.flag;
    assign output_a_o          = q_reg.pin_val[0];
    assign output_b_o          = q_reg.pin_val[1];
    assign output_c_o          = q_reg.pin_val[2];
    assign output_d_o          = q_reg.pin_val[3];
    assign output_a_oe_o       = q_reg.pin_oe[0];
    assign output_b_oe_o       = q_reg.pin_oe[1];
    assign output_c_oe_o       = q_reg.pin_oe[2];
    assign output_d_oe_o       = q_reg.pin_oe[3];

    // -----------------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------------
    default clocking ecc_cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    off_clears_a: assert property (
        q_reg.mode[3:0] == 4'h0 |=> q_reg.presc == 4'h0 && !q_reg.cmp_latch)
        else $error("off mode did not clear state");
    rsvd_quiet_a: assert property (
        (q_reg.mode[3:0] == 4'h1 || q_reg.mode[3:0] == 4'h3) && $stable(q_reg.mode)
        |=> q_reg.pin_oe == 4'h0 && !q_reg.trst1)
        else $error("reserved mode acted");
    rise_capture_a: assert property (
        q_reg.mode[3:0] == 4'h5 && rise && !wr_en
        |=> {q_reg.val_hi, q_reg.val_lo} == $past(tbase) && q_reg.flag)
        else $error("rising capture missed");
    fall_only_a: assert property (
        q_reg.mode[3:0] == 4'h4 && !fall |=> !$rose(q_reg.flag))
        else $error("falling mode captured without a fall");
    toggle_match_a: assert property (
        q_reg.mode[3:0] == 4'h2 && match_evt
        |=> q_reg.cmp_latch != $past(q_reg.cmp_latch) && q_reg.flag
        ##1 output_a_o == $past(q_reg.cmp_latch))
        else $error("toggle failed");
    set_match_a: assert property (
        q_reg.mode[3:0] == 4'h8 && match_evt && !wr_en
        |=> q_reg.cmp_latch ##1 output_a_o && output_a_oe_o)
        else $error("set on match failed");
    sw_only_a: assert property (
        q_reg.mode[3:0] == 4'hA && $stable(q_reg.mode) |=> !output_a_oe_o)
        else $error("software mode drove pin");
    spec_trig_a: assert property (
        q_reg.mode[3:0] == 4'hB && match_evt
        |=> timer_one_reset_o != timer_three_reset_o && q_reg.flag
        && timer_three_reset_o == $past(q_reg.t3ctl[ECC_TSEL_BIT])
        && adc_start_o == $past(adc_enabled_i))
        else $error("special trigger");
    fwd_bridge_a: assert property (
        q_reg.mode[7:6] == 2'b01 && q_reg.mode[3:2] == 2'b11
        |=> q_reg.pin_oe == 4'hF && output_a_o == !$past(pol_ac)
        && output_d_o == ($past(pwm_mod_i) ^ $past(pol_bd)))
        else $error("forward bridge steering");
    rev_bridge_a: assert property (
        q_reg.mode[7:6] == 2'b11 && q_reg.mode[3:2] == 2'b11
        |=> q_reg.pin_oe == 4'hF && output_c_o == !$past(pol_ac)
        && output_b_o == ($past(pwm_mod_i) ^ $past(pol_bd)))
        else $error("reverse bridge steering");
    half_bridge_a: assert property (
        q_reg.mode[7:6] == 2'b10 && q_reg.mode[3:2] == 2'b11 && $stable(q_reg.mode)
        |=> output_a_oe_o && output_b_oe_o && !output_c_oe_o
        && output_a_o == ($past(pwm_mod_i) ^ $past(pol_ac)))
        else $error("half bridge steering");
    flag_sticky_a: assert property (
        q_reg.flag && !(wr_en && wsel == 3'h5) |=> q_reg.flag)
        else $error("flag cleared by hardware");
    presc_clear_a: assert property (
        !is_cap |=> q_reg.presc == 4'h0)
        else $error("prescaler not cleared");
    presc_keep_a: assert property (
        q_reg.mode[3:0] == 4'h6 && wr_en && wsel == 3'h1 && dat_i[3:0] == 4'h7 && !rise
        |=> q_reg.presc == $past(q_reg.presc))
        else $error("prescaler lost on swap");
    sync_path_a: assert property (
        rise |-> $past(capture_pin_i, 2) && !$past(capture_pin_i, 3))
        else $error("edge not from synced pin");

    cap_cover_c:   cover property (cap_evt ##1 q_reg.flag);
    fall_cover_c:  cover property (cap_evt && q_reg.mode[3:0] == 4'h4);
    match_cover_c: cover property (match_evt && q_reg.mode[3:0] == 4'hB);
    fwd_cover_c:   cover property (q_reg.pin_oe == 4'hF && q_reg.mode[7:6] == 2'b01);
    wb_cover_c:    cover property (cyc_i && stb_i && we_i ##1 ack_o);

endmodule // ecc_unit

// file: tb/ecc_far_model.sv
// ecc_far_model: timers one, three and two plus the converter start latch
// assumes one clock with the unit; the bench freezes timers one and three through run_i
`timescale 1ns/1ns
module ecc_far_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        run_i,
    input  wire logic        t1_reset_i,
    input  wire logic        t3_reset_i,
    input  wire logic        adc_on_i,
    input  wire logic        adc_start_i,
    input  wire logic [9:0]  duty_i,
    output logic      [15:0] t1_o,
    output logic      [15:0] t3_o,
    output logic             pwm_mod_o,
    output logic             pwm_comp_o,
    output logic             adc_seen_o
);
    logic [9:0] t2_reg;

    // ----------------------------------------------------------------------
    // time bases
    // ----------------------------------------------------------------------
    // counts step on clk_i only, so the unit never sees a torn value
    always_ff @(posedge clk_i) begin
        if (rst_i || t1_reset_i) begin
            t1_o <= rst_i ? 16'h0100 : 16'h0000;
        end else if (run_i) begin
            t1_o <= t1_o + 16'h0001;
        end
        if (rst_i || t3_reset_i) begin
            t3_o <= rst_i ? 16'hC000 : 16'h0000;
        end else if (run_i) begin
            t3_o <= t3_o + 16'h0001;
        end
        adc_seen_o <= !rst_i && (adc_seen_o || (adc_start_i && adc_on_i));
    end

    // timer two runs free; odd step so the waveform moves every cycle
    always_ff @(posedge clk_i) begin
        t2_reg     <= rst_i ? 10'h000 : t2_reg + 10'h0B3;
        pwm_mod_o  <= t2_reg < duty_i;
        pwm_comp_o <= !(t2_reg < duty_i);
    end
endmodule // ecc_far_model

// file: tb/ecc_unit_tb_top.sv
// ecc_unit_tb_top: self-checking bench for the capture/compare unit
// assumes the wishbone slave acks every access and pins lag inputs by one
`timescale 1ns/1ns
module ecc_unit_tb_top
    import ecc_pkg::*;
;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, pin_i, run_r, adc_on;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o;
    logic        t1_rst, t3_rst, adc_st, mod_w, comp_w, adc_seen, flag_o;
    logic [15:0] t1_w, t3_w;
    logic [9:0]  duty_w;
    logic        a, aoe, b, boe, c, coe, d, doe;
    logic [7:0]  ppins;
    logic [4:0]  cpins;
    int          err_total, n_compared;

    assign ppins = {a, aoe, b, boe, c, coe, d, doe};
    assign cpins = {a & aoe, aoe, boe, coe, doe};

    ecc_unit dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .timer_one_count_i(t1_w), .timer_three_count_i(t3_w),
        .timer_one_reset_o(t1_rst), .timer_three_reset_o(t3_rst),
        .adc_enabled_i(adc_on), .adc_start_o(adc_st), .pwm_mod_i(mod_w),
        .pwm_comp_i(comp_w), .duty_cycle_o(duty_w), .capture_pin_i(pin_i),
        .output_a_o(a), .output_a_oe_o(aoe), .output_b_o(b), .output_b_oe_o(boe),
        .output_c_o(c), .output_c_oe_o(coe), .output_d_o(d), .output_d_oe_o(doe),
        .unit_irq_flag_o(flag_o));

    ecc_far_model far (.clk_i(clk_i), .rst_i(rst_i), .run_i(run_r),
        .t1_reset_i(t1_rst), .t3_reset_i(t3_rst), .adc_on_i(adc_on),
        .adc_start_i(adc_st), .duty_i(duty_w), .t1_o(t1_w), .t3_o(t3_w),
        .pwm_mod_o(mod_w), .pwm_comp_o(comp_w), .adc_seen_o(adc_seen));

    // ----------------------------------------------------------------------
    // common tasks
    // ----------------------------------------------------------------------
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; hold until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= ad;
        dat_i <= wd;
        sel_i <= 4'hF;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        logic [31:0] q;
        wb(1'b1, ad, wd, q);
    endtask

    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, ad, 32'h0, q);
        chk_val(q, e);
    endtask

    // slow pad pulses, wide enough for the two-flop synchroniser
    task automatic pulses(input int n);
        repeat (n) begin
            pin_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            pin_i <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        repeat (2) @(posedge clk_i);
    endtask

    // ----------------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------------
    task automatic t_reset();
        rd_chk(ECC_OFS_MODE, 32'h0);
        rd_chk(ECC_OFS_FLAG, 32'h0);
        wr(8'h14, 32'hFF);
        rd_chk(8'h14, 32'h0);
        wr(ECC_OFS_VAL_HI, 32'h3C);
        rd_chk(ECC_OFS_VAL_HI, 32'h3C);
        chk_val(32'(cpins), 32'h0);
    endtask

    task automatic t_reserved();
        for (int i = 0; i < 2; i++) begin
            wr(ECC_OFS_MODE, i ? 32'h3 : 32'h1);
            wr(ECC_OFS_FLAG, 32'h1);
            pulses(2);
            rd_chk(ECC_OFS_FLAG, 32'h0);
            chk_val(32'(cpins), 32'h0);
        end
    endtask

    task automatic t_capture();
        int          cn [4];
        logic [31:0] e;
        cn = '{1, 1, 4, 16};
        for (int i = 0; i < 4; i++) begin
            wr(ECC_OFS_MODE, 32'h0);
            wr(ECC_OFS_T3CTL, i[0] ? 32'h8 : 32'h0);
            run_r <= 1'b1;
            repeat (5) @(posedge clk_i);
            run_r <= 1'b0;
            @(posedge clk_i);
            wr(ECC_OFS_MODE, 32'(i + 4));
            wr(ECC_OFS_FLAG, 32'h1);
            if (i == 0) begin
                pin_i <= 1'b1; // a lone rise must not capture in falling mode
                repeat (2) @(posedge clk_i);
            end
            pulses(cn[i] - 1);
            rd_chk(ECC_OFS_FLAG, 32'h0);
            pulses(1);
            e = i[0] ? 32'(t3_w) : 32'(t1_w);
            rd_chk(ECC_OFS_FLAG, 32'h1);
            rd_chk(ECC_OFS_VAL_LO, e & 32'hFF);
            rd_chk(ECC_OFS_VAL_HI, e >> 8);
        end
        // direct switch keeps two counted rises, mode zero forgets them
        wr(ECC_OFS_MODE, 32'h6);
        pulses(2);
        wr(ECC_OFS_MODE, 32'h7);
        wr(ECC_OFS_FLAG, 32'h1);
        pulses(13);
        rd_chk(ECC_OFS_FLAG, 32'h0);
        pulses(1);
        rd_chk(ECC_OFS_FLAG, 32'h1);
        wr(ECC_OFS_MODE, 32'h0);
        wr(ECC_OFS_MODE, 32'h7);
        wr(ECC_OFS_FLAG, 32'h1);
        pulses(15);
        rd_chk(ECC_OFS_FLAG, 32'h0);
    endtask

    task automatic t_compare();
        logic [3:0]  md [6];
        logic [4:0]  ex [6];
        logic [15:0] x;
        int          n;
        md = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB, 4'hB};
        ex = '{5'h18, 5'h18, 5'h08, 5'h00, 5'h08, 5'h08};
        for (int i = 0; i < 6; i++) begin
            wr(ECC_OFS_MODE, 32'h0);
            // last pass runs on timer three with the converter switched on
            wr(ECC_OFS_T3CTL, (i == 5) ? 32'h8 : 32'h0);
            adc_on <= (i == 5);
            x = ((i == 5) ? t3_w : t1_w) + 16'h0014;
            wr(ECC_OFS_VAL_LO, 32'(x[7:0]));
            wr(ECC_OFS_VAL_HI, 32'(x[15:8]));
            // steering bits set on purpose; outside pwm they must not matter
            wr(ECC_OFS_MODE, {24'h0, 4'hC, md[i]});
            wr(ECC_OFS_FLAG, 32'h1);
            run_r <= 1'b1;
            n = 0;
            while (flag_o !== 1'b1 && n < 100) begin
                @(posedge clk_i);
                n++;
            end
            run_r <= 1'b0;
            repeat (3) @(posedge clk_i);
            chk_val(32'(cpins), 32'(ex[i]));
            chk_val(32'(flag_o), 32'h1);
            if (i == 4) begin
                chk_val(32'(t1_w < x), 32'h1);
                chk_val(32'(adc_seen), 32'h0);
            end
        end
        chk_val(32'(t3_w < x), 32'h1);
        chk_val(32'(adc_seen), 32'h1);
    endtask

    task automatic t_pwm();
        logic [7:0] e, k;
        logic       pa, pb, ma, mc;
        wr(ECC_OFS_VAL_LO, 32'hA7);
        for (int m = 0; m < 16; m++) begin
            pa = m[1];
            pb = m[0];
            wr(ECC_OFS_MODE, {24'h0, m[3:2], 4'hF, m[1:0]});
            chk_val(32'(duty_w), 32'h29F);
            k = (m[3:2] == 2'b00) ? 8'hD5 : (m[3:2] == 2'b10) ? 8'hF5 : 8'hFF;
            repeat (4) begin
                @(posedge clk_i);
                ma = mod_w;
                mc = comp_w;
                #1;
                case (m[3:2])
                    2'b00: e = {ma ^ pa, 7'b1000000};
                    2'b01: e = {~pa, 1'b1, pb, 1'b1, pa, 1'b1, ma ^ pb, 1'b1};
                    2'b10: e = {ma ^ pa, 1'b1, mc ^ pb, 1'b1, 4'b0000};
                    default: e = {pa, 1'b1, ma ^ pb, 1'b1, ~pa, 1'b1, pb, 1'b1};
                endcase
                chk_val(32'(ppins & k), 32'(e));
            end
        end
    endtask

    // ----------------------------------------------------------------------
    // clock, main sequence and watchdog
    // ----------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        {rst_i, cyc_i, stb_i, we_i, pin_i, run_r, adc_on} = 7'b1000001;
        {adr_i, sel_i, dat_i} = '0;
        err_total = 0;
        n_compared = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_reserved();
        t_capture();
        t_compare();
        t_pwm();
        complete_run();
    end

    // full run is about a thousand cycles; this leaves wide margin
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        complete_run();
    end
endmodule // ecc_unit_tb_top
